// File: common/ldcd_pkg.sv
// constants, register map and carrier types of the loop detector config and diagnostics block
// Behaviour
// R1 - elapsed LED turn-off interval switches LEDs off
// R2 - button or service traffic relights, restarts interval
// R3 - interval zero keeps LEDs permanently lit
// R4 - data bus baud rate configurable, default 9600
// R5 - flag selects leader or follower sync role
// R6 - disabled backplane flag uses stored bus address
// R7 - changing backplane flag triggers detector reset
// R8 - per channel occupied, error, sticky history bits
// R9 - error history cleared only by power-on reset
// R10 - count every channel alignment since power-on
// R11 - exceedances counted separately and in total alignments
// R12 - hold exceedance aligns channel, bumps exceedance count
// R13 - clear command zeroes counters, causes, amplitudes
// R14 - inductance reported in 10 microhenry steps
// R15 - occupied follows detuning versus turn-on threshold
// R16 - peak detuning kept, reinitialised at alignment
// R17 - alignment cause recorded per channel
// R18 - partner malfunction aligns whole double loop pair
// R19 - low norm value restarts calibration, logs cause
// R20 - backplane base address, next systems consecutive
// R21 - all address inputs high disables backplane addressing
// R22 - reset counter and bit-coded latest reset cause
// R23 - hold expiry resets channel, ignores present vehicle
package ldcd_pkg;
  // ==========================================================
  // sizes
  localparam int NCH = 4;
  localparam int BPW = 5;
  // ==========================================================
  // timing: one base tick of 1 ms
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEDT = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RSTI = 8'h10;
  localparam logic [7:0] OFS_BPA = 8'h14;
  // per channel groups, channel in address bits 3:2
  localparam logic [3:0] GRP_ACNT = 4'h2;
  localparam logic [3:0] GRP_CMAX = 4'h3;
  localparam logic [3:0] GRP_IND = 4'h4;
  localparam logic [3:0] GRP_THR = 4'h5;
  localparam logic [3:0] GRP_HOLD = 4'h6;
  // ==========================================================
  // control, status and backplane address register fields
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_LEAD = 3;
  localparam int CTRL_BPEN = 4;
  localparam int CTRL_DBL = 5;
  localparam int CTRL_CLR = 8;
  localparam int STAT_LED = 16;
  localparam int BPA_ACT = 8;
  // ==========================================================
  // reset values and inductance step
  localparam logic [15:0] LEDT_RST = 16'hEA60;
  localparam logic [7:0] BASE_RST = 8'h01;
  localparam logic [15:0] THR_RST = 16'h0064;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic [15:0] IND_STEP = 16'h000A;
  // reset cause bits
  localparam int RC_FLAG = 0;
  localparam int RC_PIN = 1;
  localparam int RC_WDOG = 2;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    BAUD_1200 = 3'b000,
    BAUD_2400 = 3'b001,
    BAUD_4800 = 3'b010,
    BAUD_9600 = 3'b011,
    BAUD_19200 = 3'b100,
    BAUD_38400 = 3'b101
  } ldcd_baud_e;

  typedef enum logic [2:0] {
    AC_NONE = 3'b000,
    AC_OVR = 3'b001,
    AC_NORM = 3'b010,
    AC_PART = 3'b011,
    AC_HOLD = 3'b100,
    AC_USER = 3'b101,
    AC_SYNC = 3'b110,
    AC_DLMON = 3'b111
  } ldcd_cause_e;

  // measurement results of one channel
  typedef struct packed {
    logic [15:0] detune;
    logic vld;
    logic [15:0] ind;
    logic err;
    logic ovr;
    logic norm_low;
    logic stuck;
  } ldcd_chan_s;
endpackage

// File: verilog/ldcd_sync3.sv
// three stage input synchroniser with agreement filter
module ldcd_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pin side and clean output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // chain; output moves once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule

// File: verilog/ldcd_top.sv
// loop detector device configuration and diagnostic state, wishbone slave
module ldcd_top import ldcd_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // channel measurement side
  input wire ldcd_chan_s [NCH-1:0] CH_IN,
  input wire logic USER_ALIGN,
  input wire logic SVC_ACT,
  input wire logic WDOG,
  input wire logic SYNC_LOCK,
  // pins
  input wire logic BTN,
  input wire logic EXT_RST_N,
  input wire logic [BPW-1:0] BP_ADDR,
  // outputs
  output logic [NCH-1:0] OCC,
  output logic [NCH-1:0] ALIGN,
  output logic LED_ON,
  output logic DET_RST,
  output logic [2:0] BAUD_SEL,
  output logic LEADER
);
  // ==========================================================
  // pin synchronisers
  logic [BPW+1:0] pin_q;
  ldcd_sync3 #(.W(BPW + 2)) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .d({~EXT_RST_N, BTN, BP_ADDR}), // reset pin enters inverted: all pins idle low
    .q(pin_q)
  );
  logic [BPW-1:0] bp_q;
  logic btn_q;
  logic xrst_q;
  logic btn_d_r;
  logic xrst_d_r;
  assign bp_q = pin_q[BPW-1:0];
  assign btn_q = pin_q[BPW];
  assign xrst_q = pin_q[BPW+1];
  // edge history of the filtered pins, reset to their idle level
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      btn_d_r <= 1'b0;
      xrst_d_r <= 1'b0;
    end else begin
      btn_d_r <= btn_q;
      xrst_d_r <= xrst_q;
    end
  end
  logic btn_press;
  logic xrst_fall;
  assign btn_press = btn_q & ~btn_d_r;
  assign xrst_fall = xrst_q & ~xrst_d_r;
  // ==========================================================
  // millisecond tick
  logic [15:0] pre_r;
  logic tick_r;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_r <= '0;
      tick_r <= 1'b0;
    end else if (pre_r == 16'(TICK_CYCLES - 1)) begin
      pre_r <= '0;
      tick_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
  // ==========================================================
  // wishbone access decode
  logic req;
  logic wr;
  logic [3:0] grp;
  logic [1:0] ach;
  assign req = WB_CYC_I & WB_STB_I;
  assign wr = req & WB_WE_I & WB_ACK_O & WB_SEL_I[0];
  assign grp = WB_ADR_I[7:4];
  assign ach = WB_ADR_I[3:2];

  // ==========================================================
  // device registers
  logic [2:0] baud_r;
  logic lead_r;
  logic bpen_r;
  logic dbl_r;
  logic [15:0] ledt_r;
  logic [7:0] base_r;
  logic clr;
  logic ctrl_wr;
  logic sync_chg;
  logic flag_chg;
  assign ctrl_wr = wr && WB_ADR_I == OFS_CTRL;
  assign clr = ctrl_wr && WB_DAT_I[CTRL_CLR]; // [R13]
  assign flag_chg = ctrl_wr && WB_DAT_I[CTRL_BPEN] != bpen_r; // [R7]
  assign sync_chg = ctrl_wr && !SYNC_LOCK && WB_DAT_I[CTRL_LEAD] != lead_r;
  // control, led time and stored address
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      baud_r <= BAUD_9600; // [R4]
      lead_r <= 1'b0;
      bpen_r <= 1'b1;
      dbl_r <= 1'b1;
      ledt_r <= LEDT_RST;
      base_r <= BASE_RST;
    end else if (wr) begin
      if (WB_ADR_I == OFS_CTRL) begin
        baud_r <= WB_DAT_I[CTRL_BAUD_LSB +: 3]; // [R4]
        // a follower already locked to a leader may not become leader
        if (!SYNC_LOCK) begin
          lead_r <= WB_DAT_I[CTRL_LEAD]; // [R5]
        end
        bpen_r <= WB_DAT_I[CTRL_BPEN];
        dbl_r <= WB_DAT_I[CTRL_DBL];
      end
      if (WB_ADR_I == OFS_LEDT) begin
        ledt_r <= WB_DAT_I[15:0];
      end
      if (WB_ADR_I == OFS_BASE) begin
        base_r <= WB_DAT_I[7:0];
      end
    end
  end
  // ==========================================================
  // detector reset, reset counter and cause
  logic rst_evt;
  logic [2:0] rst_bits;
  logic [15:0] rcnt_r;
  logic [7:0] rcause_r;
  assign rst_bits = {WDOG, xrst_fall, flag_chg};
  assign rst_evt = |rst_bits;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rcnt_r <= '0;
      rcause_r <= '0;
      DET_RST <= 1'b0;
    end else begin
      DET_RST <= rst_evt; // [R7]
      if (clr) begin
        rcnt_r <= {15'h0000, rst_evt}; // [R13]
        rcause_r <= {5'h00, rst_bits};
      end else if (rst_evt) begin
        rcnt_r <= rcnt_r + 16'h0001; // [R22]
        rcause_r <= {5'h00, rst_bits}; // [R22]
      end
    end
  end
  // ==========================================================
  // front panel LED timer
  logic [15:0] lcnt_r;
  logic wake;
  assign wake = btn_press | SVC_ACT;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lcnt_r <= '0;
      LED_ON <= 1'b1;
    end else if (ledt_r == 16'h0000) begin
      lcnt_r <= '0;
      LED_ON <= 1'b1; // [R3]
    end else if (wake) begin
      lcnt_r <= '0;
      LED_ON <= 1'b1; // [R2]
    end else if (LED_ON && tick_r) begin
      lcnt_r <= lcnt_r + 16'h0001;
      if (lcnt_r + 16'h0001 >= ledt_r) begin
        LED_ON <= 1'b0; // [R1]
      end
    end
  end
  // ==========================================================
  // backplane addressing
  logic bp_act;
  assign bp_act = bpen_r && !(&bp_q); // [R6] [R21]

  // ==========================================================
  // per channel diagnostics
  logic [NCH-1:0] err_d_r;
  logic [NCH-1:0] err_rise;
  logic [NCH-1:0] hist_r;
  logic [NCH-1:0] hexc;
  logic [NCH-1:0] aln;
  logic [15:0] acnt_r [NCH];
  logic [15:0] hcnt_r [NCH];
  logic [15:0] max_r [NCH];
  logic [2:0] cause_r [NCH];
  logic [15:0] thr_r [NCH];
  logic [15:0] hold_r [NCH];
  logic [15:0] ind_q [NCH];
  logic [7:0] badr [NCH];
  logic user_all;
  assign user_all = USER_ALIGN | rst_evt;
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int P = i ^ 1;
    logic [2:0] cause_nxt;
    logic [15:0] htim_r;
    logic ign_r;
    logic [7:0] sys;
    logic [15:0] hnext;
    assign err_rise[i] = CH_IN[i].err & ~err_d_r[i];
    assign hnext = htim_r + 16'h0001;
    // exceedance only with a finite hold time
    assign hexc[i] = OCC[i] && tick_r && hold_r[i] != 16'h0000
                     && hnext >= hold_r[i]; // [R11] [R23]
    // alignment request with cause priority
    always_comb begin
      cause_nxt = AC_NONE;
      if (CH_IN[i].ovr) begin
        cause_nxt = AC_OVR;
      end else if (CH_IN[i].norm_low) begin
        cause_nxt = AC_NORM; // [R19]
      end else if (dbl_r && err_rise[P]) begin
        cause_nxt = AC_PART;
      end else if (hexc[i]) begin
        cause_nxt = AC_HOLD; // [R12]
      end else if (user_all) begin
        cause_nxt = AC_USER;
      end else if (sync_chg) begin
        cause_nxt = AC_SYNC;
      end else if (dbl_r && (CH_IN[i].stuck || CH_IN[P].stuck)) begin
        cause_nxt = AC_DLMON; // [R18]
      end
    end
    assign aln[i] = cause_nxt != AC_NONE; // [R17]
    // threshold and hold time set by software
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        thr_r[i] <= THR_RST;
        hold_r[i] <= HOLD_RST;
      end else if (wr && ach == 2'(i)) begin
        if (grp == GRP_THR) begin
          thr_r[i] <= WB_DAT_I[15:0];
        end
        if (grp == GRP_HOLD) begin
          hold_r[i] <= WB_DAT_I[15:0];
        end
      end
    end
    // occupancy, ignore after hold expiry, hold timer
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        OCC[i] <= 1'b0;
        ign_r <= 1'b0;
        htim_r <= '0;
      end else begin
        if (hexc[i]) begin
          OCC[i] <= 1'b0; // [R23]
          ign_r <= 1'b1; // [R23]
        end else if (CH_IN[i].vld) begin
          if (CH_IN[i].detune > thr_r[i]) begin
            OCC[i] <= ~ign_r; // [R15]
          end else begin
            OCC[i] <= 1'b0; // [R15]
            ign_r <= 1'b0;
          end
        end
        if (!OCC[i] || hexc[i]) begin
          htim_r <= '0;
        end else if (tick_r) begin
          htim_r <= hnext;
        end
      end
    end
    // status, history, counters, cause, peak
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        err_d_r[i] <= 1'b0;
        hist_r[i] <= 1'b0; // [R9]
        ALIGN[i] <= 1'b0;
        acnt_r[i] <= '0;
        hcnt_r[i] <= '0;
        cause_r[i] <= AC_NONE;
        max_r[i] <= '0;
      end else begin
        err_d_r[i] <= CH_IN[i].err;
        if (CH_IN[i].err) begin
          hist_r[i] <= 1'b1; // [R8] [R9]
        end
        ALIGN[i] <= aln[i];
        if (clr) begin
          acnt_r[i] <= {15'h0000, aln[i]}; // [R13]
          hcnt_r[i] <= {15'h0000, hexc[i]};
          cause_r[i] <= cause_nxt;
          max_r[i] <= '0;
        end else begin
          if (aln[i]) begin
            acnt_r[i] <= acnt_r[i] + 16'h0001; // [R10] [R11]
            cause_r[i] <= cause_nxt; // [R17]
            max_r[i] <= '0; // [R16]
          end else if (CH_IN[i].vld && CH_IN[i].detune > max_r[i]) begin
            max_r[i] <= CH_IN[i].detune; // [R16]
          end
          if (hexc[i]) begin
            hcnt_r[i] <= hcnt_r[i] + 16'h0001; // [R11] [R12]
          end
        end
      end
    end
    // inductance in whole 10 uH steps
    assign ind_q[i] = CH_IN[i].ind - (CH_IN[i].ind % IND_STEP); // [R14]
    // measurement system index and its bus address
    assign sys = dbl_r ? 8'(i / 2) : 8'(i);
    assign badr[i] = (bp_act ? {3'h0, bp_q} : base_r) + sys; // [R6] [R20]
  end

  // ==========================================================
  // read data mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h00000000;
    case (grp)
      4'h0, 4'h1: begin
        case (WB_ADR_I)
          OFS_CTRL: rd = {26'h0, dbl_r, bpen_r, lead_r, baud_r};
          OFS_LEDT: rd = {16'h0000, ledt_r};
          OFS_BASE: rd = {24'h000000, base_r};
          OFS_STAT: rd = {15'h0000, LED_ON, 4'h0, hist_r, err_d_r, OCC};
          OFS_RSTI: rd = {8'h00, rcause_r, rcnt_r};
          OFS_BPA: rd = {23'h000000, bp_act, 3'h0, bp_q};
          default: rd = 32'h00000000;
        endcase
      end
      GRP_ACNT: rd = {hcnt_r[ach], acnt_r[ach]};
      GRP_CMAX: rd = {13'h0000, cause_r[ach], max_r[ach]};
      GRP_IND: rd = {8'h00, badr[ach], ind_q[ach]};
      GRP_THR: rd = {16'h0000, thr_r[ach]};
      GRP_HOLD: rd = {16'h0000, hold_r[ach]};
      default: rd = 32'h00000000;
    endcase
  end

  // ==========================================================
  // wishbone answer: one wait state, ack for one cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= req & ~WB_ACK_O;
      if (req && !WB_ACK_O) begin
        WB_DAT_O <= rd;
      end
    end
  end

  // configuration pins follow their registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BAUD_SEL <= BAUD_9600;
      LEADER <= 1'b0;
    end else begin
      BAUD_SEL <= baud_r; // [R4]
      LEADER <= lead_r; // [R5]
    end
  end
endmodule

// File: sim/ldcd_monitor.sv
// port checker of the loop detector config and diagnostics block
module ldcd_monitor import ldcd_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // register bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // channel and event side
  input wire ldcd_chan_s [NCH-1:0] CH_IN,
  input wire logic USER_ALIGN,
  input wire logic SVC_ACT,
  input wire logic WDOG,
  input wire logic EXT_RST_N,
  // observed outputs
  input wire logic [NCH-1:0] OCC,
  input wire logic [NCH-1:0] ALIGN,
  input wire logic LED_ON,
  input wire logic DET_RST
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // one clock domain, power-on reset disables everything
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // ==========================================================
  // register bus handshake
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged in the next cycle");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");

  // ==========================================================
  // alignment, occupancy, detector resets and led wake-up
  a_user_align: assert property (
    USER_ALIGN |=> ALIGN == {NCH{1'b1}})
    else $error("user alignment did not align every channel");
  a_occ_rise: assert property (
    $rose(OCC[1]) |-> $past(CH_IN[1].vld))
    else $error("occupancy set without a new detuning sample");
  a_occ_fall: assert property (
    $fell(OCC[1]) |-> $past(CH_IN[1].vld) || ALIGN[1] || DET_RST)
    else $error("occupancy dropped without sample or alignment");
  a_rst_pulse: assert property (
    DET_RST |=> !DET_RST)
    else $error("detector reset longer than one cycle");
  a_rst_aligns: assert property (
    DET_RST |-> ##[0:2] (ALIGN == {NCH{1'b1}}))
    else $error("detector reset without alignment of all channels");
  a_wdog_reset: assert property (
    WDOG |-> ##[1:2] DET_RST)
    else $error("watchdog event gave no detector reset");
  a_pin_reset: assert property (
    $fell(EXT_RST_N) |-> ##[1:8] DET_RST)
    else $error("reset pin gave no detector reset");
  a_led_wake: assert property (
    SVC_ACT |=> LED_ON)
    else $error("service traffic did not light the leds");

  // ==========================================================
  // main scenarios reached
  c_hold_align: cover property (OCC[1] ##1 (ALIGN[1] && !OCC[1]));
  c_det_rst: cover property (DET_RST);
  c_led_off: cover property ($fell(LED_ON));
endmodule

bind ldcd_top ldcd_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .CH_IN(CH_IN), .USER_ALIGN(USER_ALIGN), .SVC_ACT(SVC_ACT),
  .WDOG(WDOG), .EXT_RST_N(EXT_RST_N), .OCC(OCC), .ALIGN(ALIGN), .LED_ON(LED_ON),
  .DET_RST(DET_RST)
);

// File: sim/ldcd_tool.sv
// wishbone classic master standing in for the configuration tool
module ldcd_tool (
  // clock
  input wire logic clk,
  // master request side, idle from time zero
  output logic cyc = 1'b0,
  output logic stb = 1'b0,
  output logic we = 1'b0,
  output logic [7:0] adr = 8'h00,
  output logic [3:0] sel = 4'h0,
  output logic [31:0] dat = 32'h0000_0000,
  // slave answer
  input wire logic ack,
  input wire logic [31:0] rdat
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // one single cycle, request held until ack is sampled high or 64 cycles have passed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    ok = ack;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule

// File: sim/ldcd_bench.sv
// self-checking bench of the loop detector config and diagnostics block
module ldcd_bench import ldcd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
  } ldcd_row_s;
  // ==========================================================
  // ordinary accesses: write data, or expected read data
  localparam ldcd_row_s ROWS [12] = '{
    '{1'b0, OFS_CTRL, 32'h0000_0033}, '{1'b0, OFS_LEDT, 32'h0000_EA60},
    '{1'b0, OFS_BASE, 32'h0000_0001}, '{1'b0, 8'h50, 32'h0000_0064},
    '{1'b0, 8'h60, 32'h0000_0000}, '{1'b0, 8'h18, 32'h0000_0000},
    '{1'b1, 8'h18, 32'hFFFF_FFFF}, '{1'b0, 8'h18, 32'h0000_0000},
    '{1'b1, OFS_STAT, 32'hFFFF_FFFF}, '{1'b0, OFS_STAT, 32'h0001_0000},
    '{1'b1, OFS_CTRL, 32'h0000_0035}, '{1'b0, OFS_CTRL, 32'h0000_0035}};
  localparam ldcd_cause_e CAUSES [3] = '{AC_OVR, AC_NORM, AC_USER};
  logic clk = 1'b0, arst_n = 1'b0, ualign = 1'b0, svc = 1'b0, wdog = 1'b0;
  logic lock = 1'b0, btn = 1'b0, ext_rst_n = 1'b1;
  logic [BPW-1:0] bp = 5'h03;
  ldcd_chan_s [NCH-1:0] ch = '0;
  logic cyc, stb, we, ack, led, drst, lead;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [NCH-1:0] occ, align;
  logic [2:0] baud;
  int n_fail = 0, checks_done = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  // device and bus master
  ldcd_top #(.TICK_CYCLES(TK)) DUT (
    .CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CH_IN(ch), .USER_ALIGN(ualign), .SVC_ACT(svc), .WDOG(wdog), .SYNC_LOCK(lock),
    .BTN(btn), .EXT_RST_N(ext_rst_n), .BP_ADDR(bp), .OCC(occ), .ALIGN(align),
    .LED_ON(led), .DET_RST(drst), .BAUD_SEL(baud), .LEADER(lead));
  ldcd_tool u_tool (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wdat), .ack(ack), .rdat(rdat));

  // ==========================================================
  // shared tasks
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    u_tool.xfer(w, a, d, q, ok);
    chk(32'(ok), 32'h1);
    if (ok !== 1'b1) conclude();
  endtask
  task automatic rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0000_0000);
  endtask
  // bounded wait: alignment of channel s, dark leds (4) or detector reset (5)
  task automatic await(input int s);
    int n;
    n = 0;
    while (n < 400 && (s < NCH ? align[s] : (s == 4 ? !led : drst)) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    if (n == 400) conclude();
  endtask
  task automatic wake();
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    cyc_n(2);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] cnt;
    int i;
    ch[0].ind <= 16'h04D2;
    cyc_n(4);
    arst_n <= 1'b1;
    chk(32'({led, drst, lead, baud}), 32'h0000_0023);
    foreach (ROWS[k]) begin
      acc(ROWS[k].w, ROWS[k].a, ROWS[k].d);
      if (!ROWS[k].w) chk(q, ROWS[k].d);
    end
    chk(32'(baud), 32'(BAUD_38400));
    // leader role, blocked while locked
    rd(8'h20);
    cnt = q[15:0];
    acc(1'b1, OFS_CTRL, 32'h0000_003D);
    await(0);
    rd(8'h30);
    chk(32'(q[18:16]), 32'(AC_SYNC));
    chk(32'(lead), 32'h1);
    rd(8'h20);
    chk(32'(q[15:0]), 32'(cnt + 16'h0001));
    lock <= 1'b1;
    acc(1'b1, OFS_CTRL, 32'h0000_0035);
    cyc_n(2);
    chk(32'(lead), 32'h1);
    lock <= 1'b0;
    // bus addresses from pins, stored value and flag
    rd(8'h40);
    chk(q, 32'h0003_04CE);
    rd(8'h48);
    chk(32'(q[23:16]), 32'h4);
    acc(1'b1, OFS_CTRL, 32'h0000_0015);
    rd(8'h48);
    chk(32'(q[23:16]), 32'h5);
    bp <= 5'h1F;
    cyc_n(6);
    rd(OFS_BPA);
    chk(q, 32'h0000_001F);
    rd(8'h40);
    chk(32'(q[23:16]), 32'h1);
    bp <= 5'h03;
    rd(OFS_RSTI);
    cnt = q[15:0];
    acc(1'b1, OFS_CTRL, 32'h0000_0025);
    await(5);
    rd(8'h40);
    chk(32'(q[23:16]), 32'h1);
    rd(OFS_RSTI);
    chk(q, {8'h00, 8'h01, cnt + 16'h0001});
    // occupancy, peak and alignment causes
    ch[1].vld <= 1'b1;
    ch[1].detune <= 16'h00C8;
    cyc_n(2);
    chk(32'(occ[1]), 32'h1);
    ch[1].detune <= 16'h0032;
    cyc_n(2);
    chk(32'(occ[1]), 32'h0);
    ch[1].vld <= 1'b0;
    rd(8'h34);
    chk(32'(q[15:0]), 32'h0000_00C8);
    for (i = 0; i < 3; i++) begin
      ch[1].ovr <= (i == 0);
      ch[1].norm_low <= (i == 1);
      ualign <= (i == 2);
      @(posedge clk);
      ch[1].ovr <= 1'b0;
      ch[1].norm_low <= 1'b0;
      ualign <= 1'b0;
      await(1);
      rd(8'h34);
      chk(32'(q[18:0]), 32'({CAUSES[i], 16'h0000}));
    end
    // hold time exceedance while still occupied
    acc(1'b1, 8'h64, 32'h0000_0002);
    rd(8'h24);
    cnt = q[15:0];
    ch[1].vld <= 1'b1;
    ch[1].detune <= 16'h00C8;
    cyc_n(2);
    chk(32'(occ[1]), 32'h1);
    await(1);
    chk(32'(occ[1]), 32'h0);
    cyc_n(3);
    chk(32'(occ[1]), 32'h0);
    ch[1].vld <= 1'b0;
    rd(8'h24);
    chk(q, {16'h0001, cnt + 16'h0001});
    rd(8'h34);
    chk(32'(q[18:16]), 32'(AC_HOLD));
    // partner error, stuck partner, error history
    ch[2].err <= 1'b1;
    await(3);
    rd(8'h3C);
    chk(32'(q[18:16]), 32'(AC_PART));
    rd(OFS_STAT);
    chk(32'(q[11:4]), 32'h44);
    ch[2].err <= 1'b0;
    cyc_n(2);
    rd(OFS_STAT);
    chk(32'(q[11:4]), 32'h40);
    ch[3].stuck <= 1'b1;
    await(2);
    ch[3].stuck <= 1'b0;
    rd(8'h38);
    chk(32'(q[18:16]), 32'(AC_DLMON));
    // pin and watchdog resets
    for (i = 1; i < 3; i++) begin
      ext_rst_n <= (i != 1);
      wdog <= (i == 2);
      cyc_n(i == 1 ? 5 : 1);
      ext_rst_n <= 1'b1;
      wdog <= 1'b0;
      await(5);
      rd(OFS_RSTI);
      chk(32'(q[23:16]), 32'(8'h01 << i));
    end
    rd(OFS_STAT);
    chk(32'(q[10]), 32'h1);
    // counter clear
    acc(1'b1, OFS_CTRL, 32'h0000_0125);
    cyc_n(2);
    rd(8'h24);
    chk(q, 32'h0000_0000);
    rd(8'h38);
    chk(q, 32'h0000_0000);
    rd(OFS_RSTI);
    chk(q, 32'h0000_0000);
    // led turn-off, relight and disable
    acc(1'b1, OFS_LEDT, 32'h0000_0003);
    wake();
    await(4);
    wake();
    chk(32'(led), 32'h1);
    await(4);
    btn <= 1'b1;
    cyc_n(8);
    btn <= 1'b0;
    chk(32'(led), 32'h1);
    acc(1'b1, OFS_LEDT, 32'h0000_0000);
    wake();
    cyc_n(40);
    chk(32'(led), 32'h1);
    // power-on reset clears the error history
    arst_n <= 1'b0;
    cyc_n(2);
    arst_n <= 1'b1;
    cyc_n(6);
    rd(OFS_STAT);
    chk(32'(q[11:8]), 32'h0);
    conclude();
  end
endmodule
